// File: logic/bmw_params.svh
// Constants for the boot map and watchdog block.
// Functional notes
// - Shadow enable cleared only by power-up or watchdog
// - Boot mode: ROM at 0000/8000, RAM in data
// - Normal mode: RAM code at 0000, writes blocked
// - Bits 4..1 read fixed revision, reset-proof
// - Bits 6..5 read fixed code-space size code
// - Bit 7 reads fixed ROM/RAM code type
// - Reset clears shadow enable and USB connect
// - Firmware copies EEPROM code into RAM via data
// - Firmware sets shadow, then USB connect
// - Seven-bit watchdog on 1 ms tick, 128 ms
// - Writing 1 to bit 0 restarts watchdog
// - Watchdog stops only for pattern 10101 and 0
// - Reset: disable bit 7 one, bits 5..1 zero
// - Reset cause flag, write-one-to-clear
`ifndef BMW_PARAMS_SVH
`define BMW_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define BMW_ROM_SHADOW_CONFIG_ADDR 16'hff90
`define BMW_WATCHDOG_CONTROL_STATUS_ADDR 16'hff93

// ****************************************************************
// Field positions
// ****************************************************************
`define BMW_SHADOW_BIT 0
`define BMW_SERVICE_BIT 0
`define BMW_DIS_UP_LSB 1
`define BMW_DIS_UP_MSB 5
`define BMW_FLAG_BIT 6
`define BMW_DIS_LOW_BIT 7

// ****************************************************************
// Reset values and patterns
// ****************************************************************
`define BMW_DIS_UP_RST 5'h00
`define BMW_DIS_LOW_RST 1'b1
`define BMW_DIS_UP_KEY 5'h15
`define BMW_DIS_LOW_KEY 1'b0

// ****************************************************************
// Memory map bounds
// ****************************************************************
`define BMW_ROM_LO_END 16'h27ff
`define BMW_ROM_HI_BASE 16'h8000
`define BMW_ROM_HI_END 16'ha7ff
`define BMW_RAM_END 16'h3fff

// ****************************************************************
// Timing
// ****************************************************************
`define BMW_CLK_NS 25
`define BMW_TICK_NS 1000000
`define BMW_TICK_CYCLES (`BMW_TICK_NS / `BMW_CLK_NS)
`define BMW_WD_WIDTH 7

`endif

// File: logic/bmw_pkg.sv
// Types shared by the boot map and watchdog block.
package bmw_pkg;

  // Gray coded along run -> fire -> run; off sits beside run.
  typedef enum logic [1:0] {
    BMW_WD_RUN = 2'b00,
    BMW_WD_FIRE = 2'b01,
    BMW_WD_OFF = 2'b10
  } bmw_wd_state_t;

endpackage : bmw_pkg

// File: logic/bmw_tick.sv
// Restartable divider giving one pulse per watchdog tick period.
`timescale 1ns/100ps
module bmw_tick #(
  parameter int CYCLES = 40000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic restart,
  output logic tick
);

  localparam int W = $clog2(CYCLES);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic wrap;

  assign wrap = (cnt_reg == LAST);
  assign cnt_next = (restart || wrap) ? '0 : cnt_reg + W'(1);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick <= wrap && !restart;
    end
  end

endmodule : bmw_tick

// File: logic/bmw_top.sv
// Boot memory map switch, configuration readback and watchdog.
`timescale 1ns/100ps
`include "bmw_params.svh"
module bmw_top
  import bmw_pkg::*;
#(
  parameter int TICK_CYCLES = `BMW_TICK_CYCLES,
  // Revision value is arbitrary.
  parameter logic [3:0] REVISION = 4'h1,
  parameter logic [1:0] CODE_SIZE = 2'h2,
  parameter logic CODE_RAM = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] mcu_addr,
  input wire logic [7:0] mcu_wdata,
  input wire logic mcu_wr,
  input wire logic mcu_rd,
  output logic [7:0] mcu_rdata,
  input wire logic [15:0] code_addr,
  input wire logic code_wr,
  input wire logic [15:0] data_addr,
  input wire logic data_valid,
  input wire logic usb_bus_reset,
  input wire logic usb_connect_wr,
  input wire logic usb_connect_wdata,
  output logic code_rom_sel,
  output logic code_ram_sel,
  output logic code_wr_ok,
  output logic data_ram_sel,
  output logic shadow_enable,
  output logic usb_connect,
  output logic wd_reset
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic rom_shadow_config_hit;
  logic watchdog_control_status_hit;
  logic rom_shadow_config_wr;
  logic watchdog_control_status_wr;
  logic service_wr;

  assign rom_shadow_config_hit = (mcu_addr == `BMW_ROM_SHADOW_CONFIG_ADDR);
  assign watchdog_control_status_hit = (mcu_addr == `BMW_WATCHDOG_CONTROL_STATUS_ADDR);
  assign rom_shadow_config_wr = mcu_wr && rom_shadow_config_hit;
  assign watchdog_control_status_wr = mcu_wr && watchdog_control_status_hit;
  assign service_wr = watchdog_control_status_wr && mcu_wdata[`BMW_SERVICE_BIT];

  // ****************************************************************
  // Watchdog state
  // ****************************************************************
  bmw_wd_state_t state_reg;
  bmw_wd_state_t state_next;
  logic [`BMW_WD_WIDTH-1:0] count_reg;
  logic [`BMW_WD_WIDTH-1:0] count_next;
  logic [4:0] dis_up_reg;
  logic [4:0] dis_up_next;
  logic dis_low_reg;
  logic dis_low_next;
  logic flag_reg;
  logic flag_next;
  logic shadow_next;
  logic connect_next;
  logic tick;
  logic disabled;
  logic expire;
  logic fire;

  bmw_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .restart(service_wr),
    .tick(tick)
  );

  // Disable is judged on the stored bits, so a write takes hold
  // one cycle later.
  assign disabled = (dis_up_reg == `BMW_DIS_UP_KEY)
    && (dis_low_reg == `BMW_DIS_LOW_KEY);
  // The last tick of count 127 is the 128th millisecond.
  assign expire = (state_reg == BMW_WD_RUN) && tick && !service_wr
    && (&count_reg);
  assign fire = (state_reg == BMW_WD_FIRE);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      BMW_WD_RUN:
      begin
        if (expire)
          state_next = BMW_WD_FIRE;
        else if (disabled)
          state_next = BMW_WD_OFF;
      end
      BMW_WD_FIRE:
        state_next = BMW_WD_RUN;
      BMW_WD_OFF:
      begin
        if (!disabled)
          state_next = BMW_WD_RUN;
      end
      default:
        state_next = BMW_WD_RUN;
    endcase
  end

  // Count is held at zero while stopped, so re-enabling gives a full
  // period before a time-out.
  assign count_next = (fire || service_wr || state_reg != BMW_WD_RUN)
    ? '0
    : (tick ? count_reg + `BMW_WD_WIDTH'(1) : count_reg);

  // ****************************************************************
  // Control and status fields
  // ****************************************************************
  // A time-out restores the disable bits like a power-up would.
  assign dis_up_next = fire ? `BMW_DIS_UP_RST
    : (watchdog_control_status_wr ? mcu_wdata[`BMW_DIS_UP_MSB:`BMW_DIS_UP_LSB]
    : dis_up_reg);
  assign dis_low_next = fire ? `BMW_DIS_LOW_RST
    : (watchdog_control_status_wr ? mcu_wdata[`BMW_DIS_LOW_BIT] : dis_low_reg);

  // Setting events win over a same-cycle write-one clear.
  assign flag_next = (fire || usb_bus_reset) ? 1'b1
    : ((watchdog_control_status_wr && mcu_wdata[`BMW_FLAG_BIT]) ? 1'b0
    : flag_reg);

  // Software can only set the shadow bit; a time-out clears it.
  assign shadow_next = fire ? 1'b0
    : ((rom_shadow_config_wr && mcu_wdata[`BMW_SHADOW_BIT]) ? 1'b1
    : shadow_enable);

  // Connect is not interlocked with shadow: host download needs it
  // while still in boot mode.
  assign connect_next = fire ? 1'b0
    : (usb_connect_wr ? usb_connect_wdata : usb_connect);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= BMW_WD_RUN;
      count_reg <= '0;
      dis_up_reg <= `BMW_DIS_UP_RST;
      dis_low_reg <= `BMW_DIS_LOW_RST;
      flag_reg <= 1'b0;
      shadow_enable <= 1'b0;
      usb_connect <= 1'b0;
      wd_reset <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      dis_up_reg <= dis_up_next;
      dis_low_reg <= dis_low_next;
      flag_reg <= flag_next;
      shadow_enable <= shadow_next;
      usb_connect <= connect_next;
      wd_reset <= expire;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] rom_shadow_config_view;
  logic [7:0] watchdog_control_status_view;
  logic [7:0] rdata_next;

  // Fixed fields come from parameters, so no reset touches them.
  assign rom_shadow_config_view = {CODE_RAM, CODE_SIZE, REVISION,
    shadow_enable};
  assign watchdog_control_status_view = {dis_low_reg, flag_reg, dis_up_reg,
    1'b0};
  assign rdata_next = rom_shadow_config_hit ? rom_shadow_config_view
    : (watchdog_control_status_hit ? watchdog_control_status_view : 8'h00);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mcu_rdata <= 8'h00;
    else if (mcu_rd)
      mcu_rdata <= rdata_next;
  end

  // ****************************************************************
  // Memory map
  // ****************************************************************
  logic in_rom_lo;
  logic in_rom_hi;
  logic in_ram_code;
  logic in_ram_data;
  logic rom_sel_next;
  logic ram_sel_next;
  logic wr_ok_next;
  logic data_sel_next;

  assign in_rom_lo = (code_addr <= `BMW_ROM_LO_END);
  assign in_rom_hi = (code_addr >= `BMW_ROM_HI_BASE)
    && (code_addr <= `BMW_ROM_HI_END);
  assign in_ram_code = (code_addr <= `BMW_RAM_END);
  assign in_ram_data = (data_addr <= `BMW_RAM_END);

  // Reset leaves shadow clear, so the first fetch at 0000h hits ROM.
  assign rom_sel_next = shadow_enable ? in_rom_hi
    : (in_rom_lo || in_rom_hi);
  assign ram_sel_next = shadow_enable && in_ram_code;
  // Code space holds only ROM in boot mode, so no write ever lands.
  assign wr_ok_next = 1'b0 && code_wr;
  // Loader copies into RAM through data space in boot mode only.
  assign data_sel_next = !shadow_enable && data_valid
    && in_ram_data;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      code_rom_sel <= 1'b0;
      code_ram_sel <= 1'b0;
      code_wr_ok <= 1'b0;
      data_ram_sel <= 1'b0;
    end
    else
    begin
      code_rom_sel <= rom_sel_next;
      code_ram_sel <= ram_sel_next;
      code_wr_ok <= wr_ok_next;
      data_ram_sel <= data_sel_next;
    end
  end

endmodule : bmw_top

// File: testbench/bmw_fw.sv
// Firmware model driving the register strobes and the connect bit.
`timescale 1ns/100ps
module bmw_fw (
  input wire logic clk_sys,
  output logic [15:0] mcu_addr,
  output logic [7:0] mcu_wdata,
  output logic mcu_wr,
  output logic mcu_rd,
  output logic usb_connect_wr,
  output logic usb_connect_wdata
);
  initial {mcu_addr, mcu_wdata, mcu_wr, mcu_rd} = 26'h0;
  initial {usb_connect_wr, usb_connect_wdata} = 2'h0;
  // Released address and data lines show the inverse so a stale value is never trusted.
  task automatic acc(input logic [15:0] a, input logic [7:0] d,
    input logic w);
    @(posedge clk_sys);
    mcu_addr <= a;
    mcu_wdata <= d;
    mcu_wr <= w;
    mcu_rd <= !w;
    @(posedge clk_sys);
    mcu_addr <= ~a;
    mcu_wdata <= ~d;
    mcu_wr <= 1'b0;
    mcu_rd <= 1'b0;
  endtask : acc
  // The map switch goes first so enumeration sees the loaded code.
  task automatic boot();
    acc(16'hff90, 8'h01, 1'b1);
    @(posedge clk_sys);
    usb_connect_wr <= 1'b1;
    usb_connect_wdata <= 1'b1;
    @(posedge clk_sys);
    usb_connect_wr <= 1'b0;
    usb_connect_wdata <= 1'b0;
  endtask : boot
endmodule : bmw_fw

// File: testbench/bmw_top_assertions.sv
// Checker of map, reset and watchdog timing at the block ports.
`timescale 1ns/100ps
module bmw_chk #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] mcu_addr,
  input wire logic [7:0] mcu_wdata,
  input wire logic mcu_wr,
  input wire logic [15:0] code_addr,
  input wire logic [15:0] data_addr,
  input wire logic data_valid,
  input wire logic code_rom_sel,
  input wire logic code_ram_sel,
  input wire logic code_wr_ok,
  input wire logic data_ram_sel,
  input wire logic shadow_enable,
  input wire logic usb_connect,
  input wire logic wd_reset
);
  localparam int LO = 127 * TICK_CYCLES;
  localparam int HI = 128 * TICK_CYCLES + 3;
  logic [31:0] cnt_reg;
  logic off_reg;
  wire wd_wr = mcu_wr && mcu_addr == 16'hff93;
  wire key = !mcu_wdata[7] && mcu_wdata[5:1] == 5'h15;
  // Cycles since the count restarted; slack covers the divider phase.
  wire clr = rst || wd_reset || off_reg || (wd_wr && mcu_wdata[0]);
  always_ff @(posedge clk_sys)
  begin
    cnt_reg <= clr ? 32'h0 : cnt_reg + 32'h1;
    off_reg <= (rst || wd_reset) ? 1'b0 : (wd_wr ? key : off_reg);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_NO_CODE_WR: assert property (!code_wr_ok)
    else $error("code write accepted");
  AST_SHADOW_CLR: assert property ($fell(shadow_enable) |->
    $past(wd_reset) || $past(rst)) else $error("shadow cleared");
  // The sampled reset guards the release edge, where the disable term
  // has already dropped but the outputs were still held in reset.
  AST_BOOT_ROM: assert property (!shadow_enable && !wd_reset &&
    !rst && code_addr <= 16'h27ff |=> code_rom_sel) else $error("boot rom");
  AST_NORM_MAP: assert property (shadow_enable && !wd_reset &&
    code_addr <= 16'h3fff |=> code_ram_sel && !code_rom_sel)
    else $error("code ram");
  AST_DATA_MAP: assert property (!wd_reset && data_valid &&
    data_addr <= 16'h3fff |=> data_ram_sel == !$past(shadow_enable))
    else $error("data ram");
  AST_WD_CLEAR: assert property (wd_reset |=>
    !shadow_enable && !usb_connect && !wd_reset) else $error("wd clear");
  AST_WD_EARLY: assert property (wd_reset |-> cnt_reg >= LO)
    else $error("wd early");
  AST_WD_LATE: assert property (cnt_reg <= HI)
    else $error("wd late");
  cover property (wd_reset);
  cover property ($rose(shadow_enable));
  cover property (off_reg ##1 !off_reg);
endmodule : bmw_chk
bind bmw_top bmw_chk #(.TICK_CYCLES(TICK_CYCLES)) bmw_chk_inst (
  .clk_sys, .rst, .mcu_addr, .mcu_wdata, .mcu_wr, .code_addr, .data_addr,
  .data_valid, .code_rom_sel, .code_ram_sel, .code_wr_ok, .data_ram_sel,
  .shadow_enable, .usb_connect, .wd_reset);

// File: testbench/tb.sv
// Self-checking bench for the boot map and watchdog block.
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] code_addr = 16'h0;
  logic [15:0] data_addr = 16'h0;
  logic code_wr = 1'b0;
  logic data_valid = 1'b0;
  logic usb_bus_reset = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'hf9d4167b;
  logic [7:0] exp_q[$];
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  wire [15:0] mcu_addr;
  wire [7:0] mcu_wdata, mcu_rdata;
  wire mcu_wr, mcu_rd, usb_connect_wr, usb_connect_wdata, code_rom_sel;
  wire code_ram_sel, code_wr_ok, data_ram_sel, shadow_enable;
  wire usb_connect, wd_reset;
  always #12.5 clk_sys = ~clk_sys;
  bmw_top #(.TICK_CYCLES(4)) bmw_top_inst (.clk_sys, .rst, .mcu_addr,
    .mcu_wdata, .mcu_wr, .mcu_rd, .mcu_rdata, .code_addr, .code_wr,
    .data_addr, .data_valid, .usb_bus_reset, .usb_connect_wr,
    .usb_connect_wdata, .code_rom_sel, .code_ram_sel, .code_wr_ok,
    .data_ram_sel, .shadow_enable, .usb_connect, .wd_reset);
  bmw_fw bmw_fw_inst (.clk_sys, .mcu_addr, .mcu_wdata, .mcu_wr, .mcu_rd,
    .usb_connect_wr, .usb_connect_wdata);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input string nm, input logic [15:0] e,
    input logic [15:0] s);
    check_count++;
    if (e !== s)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic summarize();
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bmw_fw_inst.acc(a, 8'h00, 1'b0);
  endtask : rd
  task automatic map(input logic sh, input logic [15:0] ca, da);
    logic hi;
    hi = ca >= 16'h8000 && ca <= 16'ha7ff;
    @(posedge clk_sys);
    code_addr <= ca;
    data_addr <= da;
    data_valid <= 1'b1;
    code_wr <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("map", {hi || (!sh && ca <= 16'h27ff), sh && ca <= 16'h3fff,
      !sh && da <= 16'h3fff, 1'b0},
      {code_rom_sel, code_ram_sel, data_ram_sel, code_wr_ok});
  endtask : map
  task automatic wd_wait(input int lim);
    n = 0;
    while (wd_reset !== 1'b1 && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wd_wait
  always @(posedge clk_sys)
  begin
    rd_d <= mcu_rd;
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      failures++;
      summarize();
    end
  end
  always @(negedge clk_sys)
    if (rd_d === 1'b1)
      check("mcu_rdata", exp_q.pop_front(), mcu_rdata);
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(16'hff90, 8'hc2);
    rd(16'hff93, 8'h80);
    rd(16'hff91, 8'h00);
    bmw_fw_inst.acc(16'hff90, 8'hfe, 1'b1);
    rd(16'hff90, 8'hc2);
    map(1'b0, 16'h0000, 16'h3fff);
    for (int m = 0; m < 2; m++)
    begin
      repeat (8)
      begin
        seed = xs(seed);
        map(m[0], seed[31:16], seed[15:0]);
      end
      if (m == 0)
        bmw_fw_inst.boot();
    end
    check("mode", 2'b11, {shadow_enable, usb_connect});
    rd(16'hff90, 8'hc3);
    bmw_fw_inst.acc(16'hff93, 8'h81, 1'b1);
    wd_wait(600);
    check("wd_time", 1'b1, n >= 508 && n <= 520);
    @(negedge clk_sys);
    check("wd_clr", 2'b00, {shadow_enable, usb_connect});
    rd(16'hff93, 8'hc0);
    bmw_fw_inst.acc(16'hff93, 8'h80, 1'b1);
    rd(16'hff93, 8'hc0);
    bmw_fw_inst.acc(16'hff93, 8'hc1, 1'b1);
    rd(16'hff93, 8'h80);
    bmw_fw_inst.acc(16'hff93, 8'h2a, 1'b1);
    rd(16'hff93, 8'h2a);
    wd_wait(600);
    check("wd_off", 1'b0, wd_reset);
    for (int k = 0; k < 2; k++)
    begin
      bmw_fw_inst.acc(16'hff93, k ? 8'h29 : 8'hab, 1'b1);
      wd_wait(600);
      check("wd_run", 1'b1, n >= 508 && n <= 520);
    end
    bmw_fw_inst.acc(16'hff93, 8'hc1, 1'b1);
    @(posedge clk_sys);
    usb_bus_reset <= 1'b1;
    @(posedge clk_sys);
    usb_bus_reset <= 1'b0;
    rd(16'hff93, 8'hc0);
    summarize();
  end
endmodule : tb
